// ==== isu_update_control.sv ====
// In-system flash update controller: registers, access key and flash sequencing.
// Assumes an Avalon-MM master on mclk and flash arrays answering on mclk.
//
// Function
// - Setting the update enable starts the internal 22.1184 MHz RC oscillator.
// - Bit 0 of the chip control register turns the update function on or off.
// - The operation control register holds address 17:16, output and chip enable, action.
// - The address high register gives flash address bits 15:8.
// - The address low register gives flash address bits 7:0.
// - Operation control value 0x30 is standby, so a trigger changes no flash.
// - Chip control and trigger writes need keys 0xaa then 0x55 just before them.
// - Writing one to trigger bit 0 starts the operation currently selected.
// - Action 0x0b reads the maker code into the data register.
// - Update operations keep working while the code lock is active.
// - Code in either flash region can read its own region through this block.
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/100ps
`default_nettype none
module isu_update_control (
    input  wire logic                       mclk,            // 10 MHz clock
    input  wire logic                       reset_n,         // Async reset, active low
    input  wire logic [7:0]                 avs_address,     // Register index
    input  wire logic                       avs_read,        // Read request
    input  wire logic                       avs_write,       // Write request
    input  wire logic [31:0]                avs_writedata,   // Write data
    output logic [31:0]                     avs_readdata,    // Read data
    output logic                            avs_waitrequest, // Low for one accept cycle
    output isu_pkg::isu_flash_cmd_type      flash_cmd,       // Held command to the arrays
    output logic                            flash_req,       // Operation in progress
    input  wire logic                       flash_done,      // Completion pulse
    input  wire logic [7:0]                 flash_rdata,     // Byte valid with flash_done
    output logic                            rc_osc_enable    // Runs the timing oscillator
);
    import isu_pkg::*;

    logic                rst_meta;
    logic                rst_n;
    logic                wr_accept;
    logic                rd_start;
    logic                key_open;
    logic                start_op;
    logic [7:0]          wbyte;
    logic [7:0]          op_control;
    logic [7:0]          addr_high;
    logic [7:0]          addr_low;
    logic [7:0]          data_reg;
    logic                update_enable;
    logic [7:0]          next_rdata;
    isu_key_state_type   key_state;
    isu_flash_state_type fl_state;

    function automatic logic is_read_action(input logic [3:0] code);
        is_read_action = (code == ACT_READ_BYTE) || (code == ACT_READ_MAKER);
    endfunction

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    assign wbyte     = avs_writedata[7:0];
    assign wr_accept = avs_write && !avs_waitrequest;
    assign rd_start  = (avs_read || avs_write) && avs_waitrequest;
    assign key_open  = (key_state == KEY_OPEN);
    // No lock or region check gates a start: locked or boot-region code may still update
    assign start_op  = wr_accept && (avs_address == IDX_TRIGGER) && key_open
                       && wbyte[GO_BIT] && update_enable && (fl_state == FL_IDLE);

    // Every access is answered on the second edge: one wait cycle, then accept
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
        end else if (rd_start) begin
            avs_waitrequest <= 1'b0;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    always_comb begin
        next_rdata = RST_ZERO;
        if (avs_address == IDX_CHIP_CONTROL) begin
            next_rdata[ENABLE_BIT] = update_enable;
        end else if (avs_address == IDX_TRIGGER) begin
            next_rdata[BUSY_BIT] = (fl_state == FL_RUN);
        end else if (avs_address == IDX_DATA) begin
            next_rdata = data_reg;
        end else if (avs_address == IDX_ADDR_LOW) begin
            next_rdata = addr_low;
        end else if (avs_address == IDX_ADDR_HIGH) begin
            next_rdata = addr_high;
        end else if (avs_address == IDX_OP_CONTROL) begin
            next_rdata = op_control;
        end else begin
            next_rdata = RST_ZERO;
        end
    end

    // Unmapped indices read as zero; bits above the byte read as zero
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (rd_start && avs_read) begin
            avs_readdata <= {24'h00_0000, next_rdata};
        end
    end

    // Any write other than the expected key byte closes the window, so the
    // protected write has to be the very next write after the two keys
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            key_state <= KEY_IDLE;
        end else if (wr_accept) begin
            if (avs_address != IDX_ACCESS_KEY) begin
                key_state <= KEY_IDLE;
            end else if (wbyte == KEY_FIRST) begin
                key_state <= KEY_HALF;
            end else if (key_state == KEY_HALF && wbyte == KEY_SECOND) begin
                key_state <= KEY_OPEN;
            end else begin
                key_state <= KEY_IDLE;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            update_enable <= 1'b0;
        end else if (wr_accept && avs_address == IDX_CHIP_CONTROL && key_open) begin
            update_enable <= wbyte[ENABLE_BIT];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rc_osc_enable <= 1'b0;
        end else begin
            rc_osc_enable <= update_enable;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            op_control <= RST_OP_CONTROL;
            addr_high  <= RST_ZERO;
            addr_low   <= RST_ZERO;
        end else if (wr_accept) begin
            if (avs_address == IDX_OP_CONTROL) begin
                op_control <= wbyte;
            end else if (avs_address == IDX_ADDR_HIGH) begin
                addr_high <= wbyte;
            end else if (avs_address == IDX_ADDR_LOW) begin
                addr_low <= wbyte;
            end
        end
    end

    // Data register: software loads program bytes, reads land here on completion
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            data_reg <= RST_ZERO;
        end else if (fl_state == FL_RUN && flash_done
                     && is_read_action(flash_cmd.flash_action_code)) begin
            data_reg <= flash_rdata;
        end else if (wr_accept && avs_address == IDX_DATA) begin
            data_reg <= wbyte;
        end
    end

    // The command is frozen at start so register writes during a run are harmless
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fl_state  <= FL_IDLE;
            flash_req <= 1'b0;
            flash_cmd <= '0;
        end else begin
            case (fl_state)
                FL_IDLE: begin
                    if (start_op && op_control != OP_STANDBY) begin
                        fl_state  <= FL_RUN;
                        flash_req <= 1'b1;
                        flash_cmd.flash_target_address <=
                            {op_control[ADDR_HI_MSB:ADDR_HI_LSB], addr_high, addr_low};
                        flash_cmd.flash_output_enable_bit <= op_control[OE_BIT];
                        flash_cmd.flash_chip_enable_bit   <= op_control[CE_BIT];
                        flash_cmd.flash_action_code       <= op_control[ACTION_MSB:0];
                        flash_cmd.write_byte              <= data_reg;
                    end
                end
                FL_RUN: begin
                    if (flash_done) begin
                        fl_state  <= FL_IDLE;
                        flash_req <= 1'b0;
                    end
                end
                default: begin
                    fl_state  <= FL_IDLE;
                    flash_req <= 1'b0;
                end
            endcase
        end
    end

    sequence key_pair_s;
        (wr_accept && avs_address == IDX_ACCESS_KEY && wbyte == KEY_FIRST)
        ##[1:3] (wr_accept && avs_address == IDX_ACCESS_KEY && wbyte == KEY_SECOND);
    endsequence

    sequence keyed_enable_s;
        key_pair_s ##[1:3] (wr_accept && avs_address == IDX_CHIP_CONTROL);
    endsequence

    enable_keyed_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_accept && avs_address == IDX_CHIP_CONTROL && !key_open)
        |=> $stable(update_enable))
        else $error("chip control changed without access key");

    enable_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
        keyed_enable_s |=> (update_enable == $past(wbyte[ENABLE_BIT])))
        else $error("keyed enable write not applied");

    osc_follows_a: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(update_enable) |=> rc_osc_enable ##0 $past(rc_osc_enable) == 1'b0)
        else $error("oscillator did not start one cycle after enable");

    trigger_start_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (start_op && op_control != OP_STANDBY) |=> flash_req && fl_state == FL_RUN)
        else $error("trigger did not start operation");

    standby_idle_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (fl_state == FL_IDLE && op_control == OP_STANDBY) |=> !flash_req)
        else $error("standby trigger reached flash");

    target_addr_a: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(flash_req) |-> flash_cmd.flash_target_address ==
            {$past(op_control[ADDR_HI_MSB:ADDR_HI_LSB]), $past(addr_high), $past(addr_low)})
        else $error("flash address does not match registers");

    action_fields_a: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(flash_req) |-> flash_cmd.flash_action_code == $past(op_control[ACTION_MSB:0])
            && flash_cmd.flash_chip_enable_bit == $past(op_control[CE_BIT]))
        else $error("flash action fields not taken from control");

    read_capture_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (flash_req && flash_done && is_read_action(flash_cmd.flash_action_code))
        |=> data_reg == $past(flash_rdata) && !flash_req)
        else $error("read byte not captured");

    data_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !(flash_req && flash_done) && !(wr_accept && avs_address == IDX_DATA)
        |=> $stable(data_reg))
        else $error("data register changed without cause");

    bus_answer_a: assert property (@(posedge mclk) disable iff (!rst_n)
        rd_start |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not one cycle wide");

endmodule
`default_nettype wire

// ==== isu_pkg.sv ====
// Constants and carrier types for the in-system flash update controller.
// Assumes a single 10 MHz clock domain shared with the register bus.
package isu_pkg;

    // Register indices; the byte address is four times the index
    localparam logic [7:0] IDX_CHIP_CONTROL = 8'h9f;
    localparam logic [7:0] IDX_TRIGGER      = 8'ha4;
    localparam logic [7:0] IDX_DATA         = 8'ha5;
    localparam logic [7:0] IDX_ADDR_LOW     = 8'ha6;
    localparam logic [7:0] IDX_ADDR_HIGH    = 8'ha7;
    localparam logic [7:0] IDX_OP_CONTROL   = 8'haf;
    localparam logic [7:0] IDX_ACCESS_KEY   = 8'hc7;

    localparam logic [7:0] RST_OP_CONTROL   = 8'h30;
    localparam logic [7:0] RST_ZERO         = 8'h00;
    localparam logic [7:0] OP_STANDBY       = 8'h30;

    localparam logic [7:0] KEY_FIRST        = 8'haa;
    localparam logic [7:0] KEY_SECOND       = 8'h55;

    // Field positions
    localparam int ENABLE_BIT  = 0;
    localparam int GO_BIT      = 0;
    localparam int BUSY_BIT    = 0;
    localparam int OE_BIT      = 5;
    localparam int CE_BIT      = 4;
    localparam int ADDR_HI_MSB = 7;
    localparam int ADDR_HI_LSB = 6;
    localparam int ACTION_MSB  = 3;

    // Action codes whose result is returned through the data register
    localparam logic [3:0] ACT_READ_BYTE = 4'h0;
    localparam logic [3:0] ACT_READ_MAKER = 4'hb;

    localparam real RC_OSC_MHZ = 22.1184;

    typedef struct packed {
        logic [17:0] flash_target_address;
        logic        flash_output_enable_bit;
        logic        flash_chip_enable_bit;
        logic [3:0]  flash_action_code;
        logic [7:0]  write_byte;
    } isu_flash_cmd_type;

    typedef enum {KEY_IDLE, KEY_HALF, KEY_OPEN} isu_key_state_type;
    typedef enum {FL_IDLE, FL_RUN} isu_flash_state_type;

endpackage

// ==== isu_flash_model.sv ====
// Behavioural model of the flash arrays behind the update controller.
// Assumes the controller holds flash_cmd and flash_req until flash_done.
`timescale 1ns/100ps
`default_nettype none
module isu_flash_model #(
    parameter logic [7:0] MAKER_CODE = 8'h3c   // Arbitrary maker code
) (
    input  wire logic                       mclk,        // 10 MHz clock
    input  wire logic                       reset_n,     // Async reset, active low
    input  wire isu_pkg::isu_flash_cmd_type flash_cmd,   // Held command
    input  wire logic                       flash_req,   // Operation in progress
    input  wire logic [3:0]                 latency,     // Cycles before completion
    output logic                            flash_done,  // Completion pulse
    output logic [7:0]                      flash_rdata  // Byte valid with flash_done
);
    import isu_pkg::*;
    logic [4:0]  count;
    logic [17:0] a;
    assign a = flash_cmd.flash_target_address;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            count <= 5'h00;
            flash_done <= 1'b0;
            flash_rdata <= 8'h5a;
        end else begin
            flash_done <= 1'b0;
            // Toggling pattern so a byte taken the cycle after done never matches
            flash_rdata <= ~flash_rdata;
            if (!flash_req) begin
                count <= 5'h00;
            end else if (count == {1'b0, latency}) begin
                count <= count + 5'h01;
                flash_done <= 1'b1;
                if (flash_cmd.flash_action_code == ACT_READ_MAKER) begin
                    flash_rdata <= MAKER_CODE;
                end else begin
                    flash_rdata <= a[7:0] ^ a[15:8] ^ {6'h00, a[17:16]};
                end
            end else if (count < {1'b0, latency}) begin
                count <= count + 5'h01;
            end
        end
    end
endmodule
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the flash update controller.
// Assumes the flash model file is compiled alongside the design.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import isu_pkg::*;
    localparam logic [7:0] MAKER = 8'h3c;   // Arbitrary maker code
    localparam logic [3:0] ACT_OTHER = 4'h2;   // An action that returns no byte
    logic                  mclk;
    logic                  reset_n;
    logic [7:0]            avs_address;
    logic                  avs_read;
    logic                  avs_write;
    logic [31:0]           avs_writedata;
    logic [31:0]           avs_readdata;
    logic                  avs_waitrequest;
    isu_flash_cmd_type     flash_cmd;
    logic                  flash_req;
    logic                  flash_done;
    logic [7:0]            flash_rdata;
    logic                  rc_osc_enable;
    logic [3:0]            latency;
    logic [31:0]           rdv;
    logic [17:0]           addr;
    logic [7:0]            ctl;
    logic [3:0]            act;
    logic [7:0]            wb;
    int                    n_fail;
    int                    checks_done;
    int                    n;

    isu_update_control uut (.mclk(mclk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .flash_cmd(flash_cmd), .flash_req(flash_req), .flash_done(flash_done),
        .flash_rdata(flash_rdata), .rc_osc_enable(rc_osc_enable));
    isu_flash_model #(.MAKER_CODE(MAKER)) flash (.mclk(mclk), .reset_n(reset_n),
        .flash_cmd(flash_cmd), .flash_req(flash_req), .latency(latency),
        .flash_done(flash_done), .flash_rdata(flash_rdata));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // One bus access; waits for waitrequest low, only the watchdog ends a hang
    task automatic bus(logic wr, logic [7:0] idx, logic [7:0] data);
        int k;
        k = 0;
        @(posedge mclk);
        avs_address <= idx;
        avs_writedata <= {24'h000000, data};
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge mclk);
            k++;
        end while (avs_waitrequest !== 1'b0);
        check("bus_cycles", k, 32'h2);
        rdv = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic keyed(logic [7:0] idx, logic [7:0] data);
        bus(1'b1, IDX_ACCESS_KEY, KEY_FIRST);
        bus(1'b1, IDX_ACCESS_KEY, KEY_SECOND);
        bus(1'b1, idx, data);
    endtask

    task automatic wait_req(logic level, int limit);
        n = 0;
        while (flash_req !== level && n < limit) begin
            @(posedge mclk);
            n++;
        end
    endtask

    // Actions that return nothing leave the byte software wrote last
    function automatic logic [31:0] exp_byte(logic [3:0] code, logic [17:0] a, logic [7:0] held);
        if (code == ACT_READ_MAKER) return {24'h0, MAKER};
        if (code == ACT_READ_BYTE) return {24'h0, a[7:0] ^ a[15:8] ^ {6'h00, a[17:16]}};
        return {24'h0, held};
    endfunction

    initial begin
        #(100 * 40000);
        n_fail++;
        print_verdict();
    end

    initial begin
        void'($urandom(32'h0afd));
        {avs_address, avs_read, avs_write, avs_writedata, latency} = '0;
        n_fail = 0;
        checks_done = 0;
        reset_n = 1'b0;
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (3) @(posedge mclk);
        bus(1'b0, IDX_OP_CONTROL, 8'h00);
        check("op_control", rdv, {24'h0, RST_OP_CONTROL});
        bus(1'b0, IDX_ADDR_LOW, 8'h00);
        check("addr_low", rdv, 32'h0);
        bus(1'b0, IDX_ADDR_HIGH, 8'h00);
        check("addr_high", rdv, 32'h0);
        bus(1'b0, 8'h10, 8'h00);
        check("unmapped", rdv, 32'h0);
        // An enable without the key must be ignored
        bus(1'b1, IDX_CHIP_CONTROL, 8'h01);
        bus(1'b0, IDX_CHIP_CONTROL, 8'h00);
        check("enable", rdv, 32'h0);
        check("osc", {31'h0, rc_osc_enable}, 32'h0);
        keyed(IDX_CHIP_CONTROL, 8'h01);
        bus(1'b0, IDX_CHIP_CONTROL, 8'h00);
        check("enable", rdv, 32'h1);
        check("osc", {31'h0, rc_osc_enable}, 32'h1);
        for (int i = 0; i < 8; i++) begin
            latency <= 4'($urandom_range(0, 9));
            addr = (i == 0) ? 18'h3ffff : 18'($urandom);
            act = i[0] ? ACT_READ_MAKER : (i[1] ? ACT_OTHER : ACT_READ_BYTE);
            ctl = {addr[17:16], 2'($urandom), act};
            if (ctl == OP_STANDBY) ctl[5] = 1'b0;
            wb = 8'($urandom);
            bus(1'b1, IDX_ADDR_LOW, addr[7:0]);
            bus(1'b1, IDX_ADDR_HIGH, addr[15:8]);
            bus(1'b1, IDX_OP_CONTROL, ctl);
            bus(1'b1, IDX_DATA, wb);
            bus(1'b1, IDX_TRIGGER, 8'h01);
            // A wrongly started run with short latency would be over after two edges
            wait_req(1'b1, 4);
            check("flash_req", {31'h0, flash_req}, 32'h0);
            keyed(IDX_TRIGGER, 8'h01);
            wait_req(1'b1, 4);
            check("flash_req", {31'h0, flash_req}, 32'h1);
            check("addr_top", {30'h0, flash_cmd.flash_target_address[17:16]},
                  {30'h0, ctl[7:6]});
            check("addr_mid", {24'h0, flash_cmd.flash_target_address[15:8]},
                  {24'h0, addr[15:8]});
            check("addr_low", {24'h0, flash_cmd.flash_target_address[7:0]},
                  {24'h0, addr[7:0]});
            check("action", {26'h0, flash_cmd.flash_output_enable_bit,
                  flash_cmd.flash_chip_enable_bit, flash_cmd.flash_action_code},
                  {26'h0, ctl[5:0]});
            check("write_byte", {24'h0, flash_cmd.write_byte}, {24'h0, wb});
            wait_req(1'b0, 40);
            check("flash_req", {31'h0, flash_req}, 32'h0);
            bus(1'b0, IDX_DATA, 8'h00);
            check("data", rdv, exp_byte(act, addr, wb));
            // Standby trigger must leave the flash and the data alone
            bus(1'b1, IDX_OP_CONTROL, OP_STANDBY);
            keyed(IDX_TRIGGER, 8'h01);
            wait_req(1'b1, 4);
            check("flash_req", {31'h0, flash_req}, 32'h0);
            bus(1'b0, IDX_DATA, 8'h00);
            check("data", rdv, exp_byte(act, addr, wb));
        end
        // The disable must stop the oscillator and keep a keyed 0x0b trigger from reaching the flash
        keyed(IDX_CHIP_CONTROL, 8'h00);
        repeat (2) @(posedge mclk);
        check("osc", {31'h0, rc_osc_enable}, 32'h0);
        bus(1'b1, IDX_OP_CONTROL, 8'h0b);
        keyed(IDX_TRIGGER, 8'h01);
        wait_req(1'b1, 4);
        check("flash_req", {31'h0, flash_req}, 32'h0);
        print_verdict();
    end
endmodule
`default_nettype wire
